//--- tb.sv
// Purpose: Self-checking bench for the extended write and status timing block
// Assumes: 10 MHz core clock, inputs driven 1 ns after the rising edge
// Notes: Media side drains with random stalls and reports per sector
`timescale 1ns/10ps
module tb;
  import xwcs_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, link_reset = 1'b0, reg_frame_rx = 1'b0;
  logic soft_reset_bit = 1'b0, data_frame_rx = 1'b0, pio_setup_done = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] sector_count = 16'h0000, wr_data, media_data, remaining_count;
  logic [47:0] start_lba = 48'h0, error_lba, lba;
  logic wr_valid, wr_ready, media_valid, send_reg_frame, send_pio_setup;
  logic media_ready = 1'b0, media_sector_done = 1'b0, media_uncorrectable = 1'b0;
  logic [7:0] command_status_flags, command_error_flags;
  logic host_en = 1'b0, sd_pend = 1'b0;
  logic [15:0] host_base = 16'h0000;
  logic [15:0] exp_q[$];
  int bad_count = 0, checks = 0, seed = 69595, drained = 0, fail_at = -1;

  xwcs_core i_dut (.core_clk, .srst, .link_reset, .reg_frame_rx, .soft_reset_bit, .cmd_code,
    .sector_count, .start_lba, .data_frame_rx, .pio_setup_done, .wr_data, .wr_valid, .wr_ready,
    .media_data, .media_valid, .media_ready, .media_sector_done, .media_uncorrectable,
    .command_status_flags, .command_error_flags, .remaining_count, .error_lba,
    .send_reg_frame, .send_pio_setup);
  xwcs_host_model i_host (.core_clk, .en(host_en), .base(host_base), .wr_ready, .wr_data,
    .wr_valid);

  always #50 core_clk = ~core_clk;

  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Waits for 0 report frame, 1 PIO setup frame, 2 busy
  task automatic await(int which, int lim);
    int n = 0;
    while (((which == 0 ? send_reg_frame : which == 1 ? send_pio_setup
        : command_status_flags[ST_BUSY]) !== 1'b1) && n < lim) begin
      tick(1);
      n++;
    end
    chk("wait", n < lim, 1'b1);
  endtask

  task automatic issue(logic [7:0] cmd, logic [15:0] cnt, logic [47:0] a, logic srb);
    cmd_code = cmd;
    sector_count = cnt;
    start_lba = a;
    soft_reset_bit = srb;
    reg_frame_rx = 1'b1;
    tick(1);
    reg_frame_rx = 1'b0;
    cmd_code = ~cmd;
  endtask

  task automatic wr(logic [15:0] cnt, int nsec);
    lba = {16'($random(seed)), 32'($random(seed))};
    host_base = lba[15:0];
    for (int i = 0; i < nsec * WORDS_PER_SECTOR; i++) exp_q.push_back(host_base + i[15:0]);
    drained = 0;
    issue(CMD_WRITE_EXT, cnt, lba, 1'b0);
    await(2, BUSY_SET_CYC);
    await(1, 8);
    chk("pio status", {command_status_flags[7:6], command_status_flags[3]}, 3'b011);
    host_en = 1'b1;
    data_frame_rx = 1'b1;
    tick(1);
    data_frame_rx = 1'b0;
    await(2, DATA_BUSY_CYC);
    await(0, 3000);
    host_en = 1'b0;
    chk("done status", command_status_flags[7:6], 2'b01);
  endtask

  always @(posedge core_clk) begin
    sd_pend = 1'b0;
    if (media_valid && media_ready) begin
      chk("media word", media_data, exp_q.pop_front());
      drained++;
      sd_pend = (drained % WORDS_PER_SECTOR == 0);
    end
  end

  always @(posedge core_clk) begin
    #1;
    media_sector_done = sd_pend && (drained != fail_at);
    media_uncorrectable = sd_pend && (drained == fail_at);
    media_ready = ($random(seed) % 3 != 0);
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    tick(20000);
    bad_count++;
    finish_test();
  end

  initial begin
    tick(4);
    srst = 1'b0;
    await(0, 8);
    chk("reset status", command_status_flags[7:6], 2'b01);
    $display("test reset done");
    wr(16'h0002, 2);
    chk("remaining", remaining_count, 16'h0000);
    chk("error flags", command_error_flags, 8'h00);
    $display("test write done");
    fail_at = 2 * WORDS_PER_SECTOR;
    wr(16'h0000, 2);
    chk("remaining", remaining_count, 16'hFFFF);
    chk("error address", error_lba, lba + 48'h1);
    chk("not found", command_error_flags[ER_IDNF], 1'b1);
    chk("err bit", command_status_flags[ST_ERR], 1'b1);
    chk("leftover words", exp_q.size(), 0);
    fail_at = -1;
    $display("test write error done");
    issue(8'h5A, 16'h0001, 48'h0, 1'b0);
    await(2, BUSY_SET_CYC);
    await(0, 8);
    chk("aborted", command_error_flags[ER_ABRT], 1'b1);
    chk("status", {command_status_flags[7:6], command_status_flags[0]}, 3'b011);
    $display("test non-data done");
    // host recovery: soft reset, then release it with a frame that has the soft reset bit clear
    issue(8'h00, 16'h0000, 48'h0, 1'b1);
    await(2, BUSY_SET_CYC);
    tick(2);
    issue(8'h00, 16'h0000, 48'h0, 1'b0);
    await(0, 8);
    chk("soft reset status", command_status_flags[7:6], 2'b01);
    $display("test soft reset done");
    issue(CMD_DATA_IN_GENERIC, 16'h0001, 48'h0, 1'b0);
    await(1, 8);
    chk("in status", {command_status_flags[7], command_status_flags[3]}, 2'b01);
    pio_setup_done = 1'b1;
    tick(1);
    pio_setup_done = 1'b0;
    await(2, PIO_BUSY_CYC);
    link_reset = 1'b1;
    tick(1);
    link_reset = 1'b0;
    await(0, 8);
    chk("link reset status", command_status_flags[7:6], 2'b01);
    $display("test data-in and link reset done");
    finish_test();
  end
endmodule

//--- xwcs_core.sv
// Purpose: Device-side handling of the extended multi-sector write and status timing
// Assumes: link layer delivers decoded frames as one-cycle pulses on core_clk
// Notes: Media engine sits outside; it drains the word FIFO and reports per sector
`timescale 1ns/10ps
module xwcs_core
  import xwcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic link_reset,
  input wire logic reg_frame_rx,
  input wire logic soft_reset_bit,
  input wire logic [xwcs_pkg::CMD_W-1:0] cmd_code,
  input wire logic [15:0] sector_count,
  input wire logic [47:0] start_lba,
  input wire logic data_frame_rx,
  input wire logic pio_setup_done,
  input wire logic [15:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [15:0] media_data,
  output logic media_valid,
  input wire logic media_ready,
  input wire logic media_sector_done,
  input wire logic media_uncorrectable,
  output logic [7:0] command_status_flags,
  output logic [7:0] command_error_flags,
  output logic [15:0] remaining_count,
  output logic [47:0] error_lba,
  output logic send_reg_frame,
  output logic send_pio_setup
);
  import xwcs_pkg::*;

  xwcs_state_t state_q, state_d;
  logic busy_q, ready_q, drq_q, err_q;
  logic idnf_q, abrt_q;
  logic [16:0] left_q;
  logic [47:0] lba_q;
  logic [7:0] words_q;
  logic [15:0] remaining_q;
  logic [47:0] err_lba_q;
  logic send_reg_q, send_pio_q;
  // Data-in command: no write words, waits for the PIO Setup to land
  logic data_in_q;

  // Word FIFO between host data path and media engine
  logic fifo_in_ready;
  logic [15:0] fifo_out_data;
  logic fifo_out_valid;
  wire xfer_open = (state_q == XWCS_XFER) && !err_q && !data_in_q;
  wire fifo_in_valid = wr_valid && xfer_open;

  xwcs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_data(wr_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(media_ready)
  );

  assign media_data = fifo_out_data;
  assign media_valid = fifo_out_valid;
  assign wr_ready = fifo_in_ready && xfer_open;

  function automatic logic [16:0] expand_count(input logic [15:0] c);
    expand_count = (c == 16'h0000) ? 17'h10000 : {1'b0, c};
  endfunction

  wire is_write_ext = (cmd_code == CMD_WRITE_EXT);
  wire is_data_in = (cmd_code == CMD_DATA_IN_GENERIC);
  wire new_cmd = reg_frame_rx && !soft_reset_bit && (state_q == XWCS_IDLE);
  wire last_sector = (left_q == 17'h00001);
  wire word_take = fifo_in_valid && fifo_in_ready;

  always_comb begin
    state_d = state_q;
    case (state_q)
      XWCS_RESET: state_d = XWCS_DONE;
      XWCS_IDLE: begin
        if (new_cmd) begin
          state_d = (is_write_ext || is_data_in) ? XWCS_SETUP : XWCS_DONE;
        end
      end
      XWCS_SETUP: state_d = XWCS_XFER;
      XWCS_XFER: begin
        if (err_q) begin
          state_d = XWCS_DONE;
        end else if (data_in_q && pio_setup_done) begin
          // Data-in ends once the PIO Setup reached the host
          state_d = XWCS_DONE;
        end else if (word_take && words_q == WORDS_LAST) begin
          state_d = XWCS_COMMIT;
        end
      end
      XWCS_COMMIT: begin
        if (media_uncorrectable) begin
          state_d = XWCS_DONE;
        end else if (media_sector_done) begin
          state_d = last_sector ? XWCS_DONE : XWCS_SETUP;
        end
      end
      XWCS_DONE: state_d = XWCS_IDLE;
      XWCS_SRST: begin
        if (reg_frame_rx && !soft_reset_bit) begin
          state_d = XWCS_RESET;
        end
      end
      default: state_d = XWCS_RESET;
    endcase
    if (reg_frame_rx && soft_reset_bit) begin
      state_d = XWCS_SRST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || link_reset) begin
      state_q <= XWCS_RESET;
      busy_q <= 1'b1;
      ready_q <= 1'b0;
      drq_q <= 1'b0;
      err_q <= 1'b0;
      idnf_q <= 1'b0;
      abrt_q <= 1'b0;
      left_q <= '0;
      lba_q <= '0;
      words_q <= '0;
      remaining_q <= '0;
      err_lba_q <= '0;
      data_in_q <= 1'b0;
      send_reg_q <= 1'b0;
      send_pio_q <= 1'b0;
    end else begin
      state_q <= state_d;
      send_reg_q <= 1'b0;
      send_pio_q <= 1'b0;
      if (reg_frame_rx && soft_reset_bit) begin
        busy_q <= 1'b1;
        ready_q <= 1'b0;
        drq_q <= 1'b0;
      end else begin
        case (state_q)
          XWCS_IDLE: begin
            if (new_cmd) begin
              busy_q <= 1'b1;
              err_q <= 1'b0;
              idnf_q <= 1'b0;
              drq_q <= 1'b0;
              left_q <= expand_count(sector_count);
              lba_q <= start_lba;
              abrt_q <= !is_write_ext && !is_data_in;
              // data-in goes through the PIO Setup path
              data_in_q <= is_data_in;
            end
          end
          XWCS_SETUP: begin
            busy_q <= 1'b0;
            ready_q <= 1'b1;
            drq_q <= 1'b1;
            words_q <= '0;
            send_pio_q <= 1'b1;
          end
          XWCS_XFER: begin
            if (word_take) begin
              words_q <= words_q + 8'h01;
            end
            if (data_frame_rx || (word_take && words_q == WORDS_LAST)) begin
              busy_q <= 1'b1;
              drq_q <= 1'b0;
            end
            if (data_in_q && pio_setup_done) begin
              busy_q <= 1'b1;
              drq_q <= 1'b0;
            end
          end
          XWCS_COMMIT: begin
            if (media_uncorrectable) begin
              err_q <= 1'b1;
              idnf_q <= 1'b1;
              err_lba_q <= lba_q;
            end else if (media_sector_done) begin
              left_q <= left_q - 17'h00001;
              lba_q <= lba_q + 48'h000000000001;
            end
          end
          XWCS_DONE: begin
            busy_q <= 1'b0;
            ready_q <= 1'b1;
            drq_q <= 1'b0;
            send_reg_q <= 1'b1;
            remaining_q <= left_q[15:0];
          end
          default: begin
            busy_q <= busy_q;
          end
        endcase
      end
    end
  end

  assign command_status_flags = {busy_q, ready_q, 1'b0, ready_q, drq_q, 1'b0, 1'b0,
    err_q || abrt_q};
  assign command_error_flags = {3'b000, idnf_q, 1'b0, abrt_q, 2'b00};
  assign remaining_count = remaining_q;
  assign error_lba = err_lba_q;
  assign send_reg_frame = send_reg_q;
  assign send_pio_setup = send_pio_q;

  busy_after_cmd_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    new_cmd && !link_reset |=> busy_q)
    else $error("busy not set after command frame");

  busy_soft_reset_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    reg_frame_rx && soft_reset_bit |=> busy_q && !ready_q)
    else $error("busy not set after soft reset");

  report_done_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_DONE && !reg_frame_rx |=> send_reg_frame && !busy_q && ready_q)
    else $error("completion report missing");

  stop_on_error_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    err_q |-> !wr_ready && !send_pio_setup)
    else $error("data taken after error");

  error_address_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_COMMIT && media_uncorrectable && !reg_frame_rx
    |=> error_lba == $past(lba_q) && command_error_flags[ER_IDNF])
    else $error("failing address not captured");

  zero_count_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    new_cmd && is_write_ext && sector_count == 16'h0000 |=> left_q == 17'h10000)
    else $error("zero count not expanded");

  pio_setup_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_SETUP && !reg_frame_rx |=> send_pio_setup && !busy_q ##1 !send_pio_setup)
    else $error("PIO Setup not sent once");

  data_in_drq_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    new_cmd && is_data_in |=> busy_q ##1 send_pio_setup && drq_q && !busy_q)
    else $error("data-in setup missing");

  nodata_status_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    new_cmd && !is_write_ext && !is_data_in |=> command_status_flags[ST_ERR] ##1 send_reg_frame)
    else $error("non-data completion missing");

  rebusy_data_in_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_XFER && data_in_q && pio_setup_done && !reg_frame_rx |=> busy_q && !drq_q)
    else $error("busy not set after PIO Setup");

  busy_after_data_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_XFER && data_frame_rx && !reg_frame_rx |=> busy_q && !drq_q)
    else $error("busy not set after Data frame");

  commit_advance_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_COMMIT && media_sector_done && !media_uncorrectable && !reg_frame_rx
    |=> lba_q == $past(lba_q) + 48'h000000000001 && left_q == $past(left_q) - 17'h00001)
    else $error("sector commit did not advance");

  soft_release_a:
  assert property (@(posedge core_clk) disable iff (srst || link_reset)
    state_q == XWCS_SRST && reg_frame_rx && !soft_reset_bit
    |-> ##3 send_reg_frame && !busy_q && ready_q)
    else $error("soft reset release not reported");
endmodule

//--- xwcs_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: Depth must be a power of two
`timescale 1ns/10ps
module xwcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q[AW-1:0]] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

//--- xwcs_host_model.sv
// Purpose: Host word source feeding the write data stream
// Assumes: drives 1 ns after the rising edge of core_clk
// Notes: Idle data inverts its previous value every cycle, alternating with the last word
`timescale 1ns/10ps
module xwcs_host_model (
  input wire logic core_clk,
  input wire logic en,
  input wire logic [15:0] base,
  input wire logic wr_ready,
  output logic [15:0] wr_data,
  output logic wr_valid
);
  int seed = 69595;
  logic [15:0] idx = 16'h0000;
  logic hs;
  initial begin
    wr_valid = 1'b0;
    wr_data = 16'hFFFF;
  end
  always @(posedge core_clk) begin
    hs = wr_valid && wr_ready;
    if (hs) idx = idx + 16'h0001;
    if (!en) idx = 16'h0000;
    #1;
    if (!en || !wr_valid || hs) wr_valid = en && ($random(seed) % 4 != 0);
    wr_data = wr_valid ? base + idx : ~wr_data;
  end
endmodule

//--- xwcs_pkg.sv
// Purpose: Shared constants for the extended write command and status timing block
// Assumes: core clock of 10 MHz
// Notes: Status and error bit positions follow the task-file layout
package xwcs_pkg;
  localparam int CLK_NS = 100;
  localparam int CMD_W = 8;
  localparam logic [7:0] CMD_WRITE_EXT = 8'h34;
  localparam logic [7:0] CMD_DATA_IN_GENERIC = 8'h24;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int WORDS_PER_SECTOR = 256;
  localparam logic [7:0] WORDS_LAST = 8'hFF;
  // Timing limits in their own units
  localparam int BUSY_SET_NS = 400;
  localparam int BUSY_SET_CYC = (BUSY_SET_NS / CLK_NS) < 1 ? 1 : BUSY_SET_NS / CLK_NS;
  localparam int DATA_BUSY_US = 5;
  localparam int DATA_BUSY_CYC = DATA_BUSY_US * 1000 / CLK_NS;
  localparam int PIO_BUSY_US = 10;
  localparam int PIO_BUSY_CYC = PIO_BUSY_US * 1000 / CLK_NS;
  localparam int READY_SEC = 31;
  localparam int CMD_SEC = 30;
  // Status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEK = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // Error bit positions
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  localparam logic [7:0] ZERO8 = 8'h00;
  typedef enum logic [2:0] {
    XWCS_RESET = 3'b000,
    XWCS_IDLE = 3'b001,
    XWCS_SETUP = 3'b011,
    XWCS_XFER = 3'b010,
    XWCS_COMMIT = 3'b110,
    XWCS_DONE = 3'b111,
    XWCS_SRST = 3'b101
  } xwcs_state_t;
endpackage
